// >>> verilog/rbo_pkg.sv
// Purpose: Constants for the relay bank output control register block.
// Assumes: Holding registers addressed by 16-bit register index.
// Notes:   Firing mode codes match the switching mode register encoding.
`default_nettype none
package rbo_pkg;
    // Register indices
    localparam logic [15:0] ADDR_COMP_REF   = 16'h0072;
    localparam logic [15:0] ADDR_CTRL_LEVEL = 16'h0082;
    localparam logic [15:0] ADDR_BANK_LOW   = 16'h008c;
    localparam logic [15:0] ADDR_BANK_HIGH  = 16'h008d;
    // Reset values
    localparam logic [15:0] RST_COMP_REF    = 16'h0000;
    localparam logic [15:0] RST_CTRL_LEVEL  = 16'h0000;
    localparam logic [15:0] RST_BANK        = 16'h0000;
    // Value limits
    localparam logic [15:0] COMP_REF_MIN    = 16'h002a;
    localparam logic [15:0] COMP_REF_MAX    = 16'h0258;
    localparam logic [15:0] LEVEL_MAX       = 16'h0064;
    localparam logic [15:0] LEVEL_FULL      = 16'h0064;
    // Firing mode encoding
    localparam logic [2:0]  MODE_EXTERNAL   = 3'h0;
    localparam logic [2:0]  MODE_ONOFF      = 3'h1;
    localparam logic [2:0]  MODE_BURST      = 3'h2;
    localparam logic [2:0]  MODE_ADV_FULL   = 3'h3;
    localparam logic [2:0]  MODE_DIST_FULL  = 3'h4;
    localparam logic [2:0]  MODE_PHASE      = 3'h5;
    localparam int          BANK_BITS       = 16;
endpackage : rbo_pkg
`default_nettype wire

// >>> verilog/rbo_device_out.sv
// Purpose: Output selection for one end device on the chain.
// Assumes: Mode and bank bit are registered upstream.
// Notes:   Bank bit drives the relay only in on/off mode.
`default_nettype none
module rbo_device_out (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [2:0]  mode,
    input  wire logic        bank_bit,
    input  wire logic [15:0] level,
    output logic             relay_on,
    output logic [15:0]      drive_level
);
    logic        relay_reg;
    logic        relay_next;
    logic [15:0] level_reg;
    logic [15:0] level_next;

    // Select source by firing mode
    always_comb begin
        relay_next = 1'b0;
        level_next = 16'h0000;
        case (mode)
            rbo_pkg::MODE_ONOFF: begin
                relay_next = bank_bit;
                level_next = bank_bit ? rbo_pkg::LEVEL_FULL : 16'h0000;
            end
            rbo_pkg::MODE_BURST, rbo_pkg::MODE_ADV_FULL,
            rbo_pkg::MODE_DIST_FULL, rbo_pkg::MODE_PHASE: begin
                relay_next = (level != 16'h0000);
                level_next = level;
            end
            default: begin
                relay_next = 1'b0;
                level_next = 16'h0000;
            end
        endcase
    end

    // Register outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            relay_reg <= 1'b0;
            level_reg <= 16'h0000;
        end else begin
            relay_reg <= relay_next;
            level_reg <= level_next;
        end
    end

    assign relay_on    = relay_reg;
    assign drive_level = level_reg;

    a_onoff_follow: assert property (@(posedge mclk) disable iff (reset)
        mode == rbo_pkg::MODE_ONOFF |=> relay_on == $past(bank_bit))
        else $error("relay not following bank bit in on/off mode");
    a_other_ignores: assert property (@(posedge mclk) disable iff (reset)
        (mode != rbo_pkg::MODE_ONOFF && $stable(mode) && $stable(level))
        ##1 $stable(mode) && $stable(level) |-> $stable(relay_on))
        else $error("bank write changed relay outside on/off mode");
endmodule // rbo_device_out
`default_nettype wire

// >>> verilog/rbo_regs.sv
// Purpose: Holding registers setting output behaviour of 32 relay devices.
// Assumes: Register port is a simple synchronous read/write strobe pair.
// Notes:   Firing mode per device arrives from the mode register elsewhere.
`default_nettype none
module rbo_regs #(
    parameter int NUM_DEV = 32
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic [15:0]          reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [15:0]          reg_wdata,
    output logic [15:0]               reg_rdata,
    output logic                      reg_ack,
    output logic                      reg_err,
    input  wire logic [NUM_DEV*3-1:0] dev_mode,
    input  wire logic [15:0]          mains_volts,
    output logic                      comp_enable,
    output logic [15:0]               comp_reference,
    output logic [15:0]               comp_level,
    output logic [NUM_DEV-1:0]        relay_on,
    output logic [NUM_DEV*16-1:0]     drive_level
);
    // Refuse chain lengths that the two banks cannot cover
    if (NUM_DEV < 1 || NUM_DEV > 2 * rbo_pkg::BANK_BITS) begin : g_bad_num
        $error("NUM_DEV must be 1 to 32");
    end

    logic [15:0] comp_ref_reg;
    logic [15:0] comp_ref_next;
    logic [15:0] level_reg;
    logic [15:0] level_next;
    logic [15:0] bank_low_reg;
    logic [15:0] bank_low_next;
    logic [15:0] bank_high_reg;
    logic [15:0] bank_high_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        ack_reg;
    logic        ack_next;
    logic        err_reg;
    logic        err_next;
    logic [15:0] comp_lvl_reg;
    logic [15:0] comp_lvl_next;
    logic        comp_en_reg;
    logic        comp_en_next;

    // All checks below run on the one clock, quiet during reset
    default clocking cb_chk @(posedge mclk);
    endclocking
    default disable iff (reset);

    // True for a valid compensation reference
    function automatic logic ref_valid(input logic [15:0] v);
        return (v >= rbo_pkg::COMP_REF_MIN) && (v <= rbo_pkg::COMP_REF_MAX);
    endfunction

    // True for one of the four holding register indices
    function automatic logic addr_mapped(input logic [15:0] a);
        return (a == rbo_pkg::ADDR_COMP_REF) ||
               (a == rbo_pkg::ADDR_CTRL_LEVEL) ||
               (a == rbo_pkg::ADDR_BANK_LOW) ||
               (a == rbo_pkg::ADDR_BANK_HIGH);
    endfunction

    // Clamp level to full scale
    function automatic logic [15:0] clamp_level(input logic [31:0] v);
        if (v > {16'h0000, rbo_pkg::LEVEL_MAX})
            return rbo_pkg::LEVEL_MAX;
        return v[15:0];
    endfunction

    // Register write and read decode
    always_comb begin
        comp_ref_next  = comp_ref_reg;
        level_next     = level_reg;
        bank_low_next  = bank_low_reg;
        bank_high_next = bank_high_reg;
        rdata_next     = rdata_reg;
        ack_next       = reg_wr | reg_rd;
        err_next       = 1'b0;
        if (reg_addr == rbo_pkg::ADDR_COMP_REF) begin
            if (reg_wr) begin
                // Out-of-range references other than zero are refused
                if (reg_wdata == 16'h0000 || ref_valid(reg_wdata))
                    comp_ref_next = reg_wdata;
                else
                    err_next = 1'b1;
            end
            if (reg_rd)
                rdata_next = comp_ref_reg;
        end else if (reg_addr == rbo_pkg::ADDR_CTRL_LEVEL) begin
            if (reg_wr) begin
                if (reg_wdata <= rbo_pkg::LEVEL_MAX)
                    level_next = reg_wdata;
                else
                    err_next = 1'b1;
            end
            if (reg_rd)
                rdata_next = level_reg;
        end else if (reg_addr == rbo_pkg::ADDR_BANK_LOW) begin
            if (reg_wr)
                bank_low_next = reg_wdata;
            if (reg_rd)
                rdata_next = bank_low_reg;
        end else if (reg_addr == rbo_pkg::ADDR_BANK_HIGH) begin
            if (reg_wr)
                bank_high_next = reg_wdata;
            if (reg_rd)
                rdata_next = bank_high_reg;
        end else begin
            err_next = reg_wr | reg_rd;
            if (reg_rd)
                rdata_next = 16'h0000;
        end
    end

    // Voltage compensation of the control level
    always_comb begin
        comp_en_next  = ref_valid(comp_ref_reg);
        comp_lvl_next = level_reg;
        if (comp_en_next && mains_volts != 16'h0000)
            // Scale by (ref/mains)^2 keeps load power at nominal
            comp_lvl_next = clamp_level(
                (32'(level_reg) * 32'(comp_ref_reg) / 32'(mains_volts))
                * 32'(comp_ref_reg) / 32'(mains_volts));
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            comp_ref_reg  <= rbo_pkg::RST_COMP_REF;
            level_reg     <= rbo_pkg::RST_CTRL_LEVEL;
            bank_low_reg  <= rbo_pkg::RST_BANK;
            bank_high_reg <= rbo_pkg::RST_BANK;
            rdata_reg     <= 16'h0000;
            ack_reg       <= 1'b0;
            err_reg       <= 1'b0;
            comp_lvl_reg  <= 16'h0000;
            comp_en_reg   <= 1'b0;
        end else begin
            comp_ref_reg  <= comp_ref_next;
            level_reg     <= level_next;
            bank_low_reg  <= bank_low_next;
            bank_high_reg <= bank_high_next;
            rdata_reg     <= rdata_next;
            ack_reg       <= ack_next;
            err_reg       <= err_next;
            comp_lvl_reg  <= comp_lvl_next;
            comp_en_reg   <= comp_en_next;
        end
    end

    assign reg_rdata      = rdata_reg;
    assign reg_ack        = ack_reg;
    assign reg_err        = err_reg;
    assign comp_enable    = comp_en_reg;
    assign comp_reference = comp_ref_reg;
    assign comp_level     = comp_lvl_reg;

    // One output stage per chain position
    genvar d;
    generate
        for (d = 0; d < NUM_DEV; d++) begin : g_dev
            logic bank_bit;
            if (d < rbo_pkg::BANK_BITS) begin : g_low
                assign bank_bit = bank_low_reg[d];
            end else begin : g_high
                assign bank_bit =
                    bank_high_reg[d - rbo_pkg::BANK_BITS];
            end
            rbo_device_out u_out (
                .mclk        (mclk),
                .reset       (reset),
                .mode        (dev_mode[d*3 +: 3]),
                .bank_bit    (bank_bit),
                .level       (comp_lvl_reg),
                .relay_on    (relay_on[d]),
                .drive_level (drive_level[d*16 +: 16])
            );
        end
    endgenerate

    // Reference held at zero for two cycles
    sequence s_ref_zero_held;
        comp_ref_reg == 16'h0000 ##1 comp_ref_reg == 16'h0000;
    endsequence

    // Device 1 kept in on/off mode for two cycles
    sequence s_dev0_onoff_held;
        dev_mode[2:0] == rbo_pkg::MODE_ONOFF ##1
        dev_mode[2:0] == rbo_pkg::MODE_ONOFF;
    endsequence

    // Device 1 kept under external control for two cycles
    sequence s_dev0_ext_held;
        dev_mode[2:0] == rbo_pkg::MODE_EXTERNAL ##1
        dev_mode[2:0] == rbo_pkg::MODE_EXTERNAL;
    endsequence

    // Device 1 kept in one proportional mode for two cycles
    sequence s_dev0_prop_held;
        dev_mode[2:0] >= rbo_pkg::MODE_BURST &&
        dev_mode[2:0] <= rbo_pkg::MODE_PHASE ##1
        $stable(dev_mode[2:0]);
    endsequence

    // Zero reference: no compensation, level passes straight through
    a_comp_off: assert property (
        s_ref_zero_held |-> !comp_enable ##1 comp_level == $past(level_reg))
        else $error("compensation active with zero reference");
    a_comp_on: assert property (@(posedge mclk) disable iff (reset)
        comp_ref_reg == 16'h00e6 |=> comp_enable)
        else $error("compensation not enabled for valid reference");
    a_bank_store: assert property (@(posedge mclk) disable iff (reset)
        reg_wr && reg_addr == rbo_pkg::ADDR_BANK_LOW
        |=> bank_low_reg == $past(reg_wdata))
        else $error("low bank write not stored");
    a_bank_high: assert property (@(posedge mclk) disable iff (reset)
        reg_wr && reg_addr == rbo_pkg::ADDR_BANK_HIGH
        |=> bank_high_reg == $past(reg_wdata))
        else $error("high bank write not stored");
    a_level_range: assert property (@(posedge mclk) disable iff (reset)
        level_reg <= rbo_pkg::LEVEL_MAX)
        else $error("control level above full scale");
    a_dev0_onoff: assert property (
        s_dev0_onoff_held |=> relay_on[0] == $past(bank_low_reg[0]))
        else $error("device 1 not following low bank bit 0");

    // Register port answers one cycle after every strobe
    a_ack_follows: assert property (
        (reg_wr || reg_rd) |=> reg_ack)
        else $error("no acknowledge after a strobe");

    a_ack_pulse: assert property (
        !(reg_wr || reg_rd) |=> !reg_ack && !reg_err)
        else $error("acknowledge without a strobe");

    a_err_with_ack: assert property (
        reg_err |-> reg_ack)
        else $error("error flag without acknowledge");

    // Unmapped indices are flagged and read as zero
    a_unmapped_err: assert property (
        (reg_wr || reg_rd) && !addr_mapped(reg_addr) |=> reg_err)
        else $error("unmapped index not flagged");

    a_unmapped_zero: assert property (
        reg_rd && !addr_mapped(reg_addr) |=> reg_rdata == 16'h0000)
        else $error("unmapped index read not zero");

    // Reference keeps to its legal set; bad writes leave it alone
    a_ref_legal: assert property (
        comp_ref_reg == 16'h0000 || ref_valid(comp_ref_reg))
        else $error("reference outside its legal set");

    a_ref_refused: assert property (
        reg_wr && reg_addr == rbo_pkg::ADDR_COMP_REF &&
        reg_wdata != 16'h0000 && !ref_valid(reg_wdata)
        |=> reg_err && $stable(comp_ref_reg))
        else $error("out-of-range reference accepted");

    // Without a valid reference the level is not scaled
    a_comp_bypass: assert property (
        !ref_valid(comp_ref_reg) |=> comp_level == $past(level_reg))
        else $error("level scaled without valid reference");

    a_comp_limit: assert property (
        comp_level <= rbo_pkg::LEVEL_MAX)
        else $error("compensated level above full scale");

    // Legal level writes land one cycle later
    a_level_store: assert property (
        reg_wr && reg_addr == rbo_pkg::ADDR_CTRL_LEVEL &&
        reg_wdata <= rbo_pkg::LEVEL_MAX |=> level_reg == $past(reg_wdata))
        else $error("control level write not stored");

    // Bank reads return the stored word
    a_read_low: assert property (
        reg_rd && reg_addr == rbo_pkg::ADDR_BANK_LOW
        |=> reg_rdata == $past(bank_low_reg))
        else $error("low bank read wrong");

    a_read_high: assert property (
        reg_rd && reg_addr == rbo_pkg::ADDR_BANK_HIGH
        |=> reg_rdata == $past(bank_high_reg))
        else $error("high bank read wrong");

    // Proportional modes drive the compensated level, not the bank
    a_dev0_level: assert property (
        s_dev0_prop_held |=> drive_level[15:0] == $past(comp_lvl_reg))
        else $error("device 1 not driving control level");

    // External control leaves the relay off here
    a_dev0_ext: assert property (
        s_dev0_ext_held |=> !relay_on[0] && drive_level[15:0] == 16'h0000)
        else $error("device 1 driven under external control");

    // Second bank reaches device 17 when the chain is long enough
    if (NUM_DEV > rbo_pkg::BANK_BITS) begin : g_chk_high
        a_dev16_onoff: assert property (
            @(posedge mclk) disable iff (reset)
            dev_mode[50:48] == rbo_pkg::MODE_ONOFF ##1
            dev_mode[50:48] == rbo_pkg::MODE_ONOFF
            |=> relay_on[16] == $past(bank_high_reg[0]))
            else $error("device 17 not following high bank bit 0");
    end
endmodule // rbo_regs
`default_nettype wire

// >>> verif/rbo_host_model.sv
// Purpose: Network client model issuing holding register accesses.
// Assumes: One-cycle strobe, ack sampled mid-cycle after the take edge.
// Notes:   Address and data show inverted values once released.
`default_nettype none
module rbo_host_model (
    input  wire logic        mclk,
    output logic [15:0]      reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_err
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        reg_addr = 16'hffff;
        reg_wdata = 16'hffff;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Strobe for one edge, hold qualifiers, bounded wait for ack
    task automatic access(input logic w, input logic [15:0] a,
            input logic [15:0] d, output logic [15:0] q,
            output logic e, output logic to);
        to = 1'b1;
        q = 16'h0000;
        e = 1'b0;
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        for (int i = 0; i < 4 && to; i++) begin
            @(negedge mclk);
            if (reg_ack === 1'b1) begin
                q = reg_rdata;
                e = reg_err;
                to = 1'b0;
            end
        end
        // Qualifiers stand through the answer, released on the next edge
        @(posedge mclk);
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // rbo_host_model
`default_nettype wire

// >>> verif/relay_bank_output_control_test.sv
// Purpose: Self-checking bench for the relay bank holding registers.
// Assumes: Outputs settle within three cycles of a register write.
// Notes:   Device modes are spread over all codes and rotated each pass.
`default_nettype none
module relay_bank_output_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    logic [95:0]  dev_mode = '0;
    logic [15:0]  mains_volts = '0;
    logic [15:0]  reg_addr, reg_wdata, reg_rdata, comp_reference;
    logic [15:0]  comp_level, level, q, last;
    logic         reg_wr, reg_rd, reg_ack, reg_err, comp_enable, e, to, ok;
    logic [31:0]  relay_on, bank;
    logic [31:0]  seed = 32'd79685;
    logic [511:0] drive_level;
    logic [15:0]  adr [4] = '{rbo_pkg::ADDR_COMP_REF, rbo_pkg::ADDR_CTRL_LEVEL,
                      rbo_pkg::ADDR_BANK_LOW, rbo_pkg::ADDR_BANK_HIGH};
    logic [15:0]  refv [6] = '{0, 42, 41, 600, 601, 230};
    int           num_errors = 0;
    int           n_compared = 0;
    // Clock
    always #5 mclk = ~mclk;
    rbo_host_model i_host (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));
    rbo_regs #(.NUM_DEV(32)) i_dut (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_err(reg_err), .dev_mode(dev_mode), .mains_volts(mains_volts),
        .comp_enable(comp_enable), .comp_reference(comp_reference),
        .comp_level(comp_level), .relay_on(relay_on),
        .drive_level(drive_level));
    // Xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected relay states above the drive levels
    function automatic logic [543:0] exp_out(logic [95:0] m,
            logic [31:0] b, logic [15:0] l);
        logic [543:0] r;
        logic [2:0]   md;
        r = '0;
        for (int d = 0; d < 32; d++) begin
            md = m[3*d +: 3];
            if (md == rbo_pkg::MODE_ONOFF) begin
                r[512+d] = b[d];
                r[16*d +: 16] = b[d] ? rbo_pkg::LEVEL_FULL : 16'h0000;
            end else if (md >= rbo_pkg::MODE_BURST &&
                         md <= rbo_pkg::MODE_PHASE) begin
                r[512+d] = (l != 16'h0000);
                r[16*d +: 16] = l;
            end
        end
        return r;
    endfunction
    // Square-law compensated level, clamped to full scale
    function automatic logic [15:0] exp_comp(logic [15:0] l, logic [15:0] r,
            logic [15:0] v);
        logic [31:0] t;
        t = 32'(l) * 32'(r) / 32'(v) * 32'(r) / 32'(v);
        if (t > 32'(rbo_pkg::LEVEL_MAX)) return rbo_pkg::LEVEL_MAX;
        return t[15:0];
    endfunction
    task automatic check(string nm, logic [543:0] seen, logic [543:0] ex);
        n_compared++;
        if (seen !== ex) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One access with its error flag compared
    task automatic acc(logic w, logic [15:0] a, logic [15:0] d, logic ee);
        i_host.access(w, a, d, q, e, to);
        if (to) begin
            num_errors++;
            wrap_up();
        end
        check("reg_err", e, ee);
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] ex, logic ee);
        acc(1'b0, a, 16'h0000, ee);
        check("reg_rdata", q, ex);
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        settle();
        check("outputs", {relay_on, drive_level}, '0);
        foreach (adr[i]) rd(adr[i], 16'h0000, 1'b0);
        rd(16'h0073, 16'h0000, 1'b1);
        $display("test reset done");
        // Reference values, refused ones leave the last accepted
        last = 16'h0000;
        foreach (refv[i]) begin
            ok = refv[i] == 0 || (refv[i] >= 42 && refv[i] <= 600);
            acc(1'b1, adr[0], refv[i], !ok);
            settle();
            if (ok) last = refv[i];
            check("comp_enable", comp_enable, last != 0);
            check("comp_reference", comp_reference, last);
        end
        @(posedge mclk);
        mains_volts <= 16'd230;
        level = 16'(xs() % 101);
        acc(1'b1, adr[1], level, 1'b0);
        settle();
        check("comp_level", comp_level, level);
        acc(1'b1, adr[0], 16'h0000, 1'b0);
        @(posedge mclk);
        mains_volts <= 16'(xs());
        settle();
        check("comp_level", comp_level, level);
        acc(1'b1, adr[1], 16'd101, 1'b1);
        rd(adr[1], level, 1'b0);
        // Mains below reference raises the level, clamped at full scale
        acc(1'b1, adr[0], 16'd230, 1'b0);
        @(posedge mclk);
        mains_volts <= 16'd115;
        acc(1'b1, adr[1], 16'd20, 1'b0);
        settle();
        check("comp_level", comp_level, exp_comp(16'd20, 16'd230, 16'd115));
        acc(1'b1, adr[1], 16'd50, 1'b0);
        settle();
        check("comp_level", comp_level, exp_comp(16'd50, 16'd230, 16'd115));
        acc(1'b1, adr[0], 16'h0000, 1'b0);
        $display("test compensation done");
        // Modes rotate; banks written only on even passes
        for (int p = 0; p < 8; p++) begin
            @(posedge mclk);
            for (int d = 0; d < 32; d++) dev_mode[3*d +: 3] <= 3'((d + p) % 8);
            if (p % 2 == 0) begin
                bank = xs();
                level = (p == 4) ? 16'h0000 : 16'(xs() % 101);
                if (p == 6) level = rbo_pkg::LEVEL_MAX;
                acc(1'b1, adr[2], bank[15:0], 1'b0);
                acc(1'b1, adr[3], bank[31:16], 1'b0);
                acc(1'b1, adr[1], level, 1'b0);
            end
            settle();
            check("outputs", {relay_on, drive_level},
                exp_out(dev_mode, bank, level));
            rd(adr[2], bank[15:0], 1'b0);
            rd(adr[3], bank[31:16], 1'b0);
        end
        $display("test modes done");
        wrap_up();
    end
endmodule // relay_bank_output_control_test
`default_nettype wire
